// File: core/pla_tail_map.svh
`ifndef PLA_TAIL_MAP_SVH
`define PLA_TAIL_MAP_SVH

// byte addresses of the registers
`define ADDR_IRQ_SELECT_LOW 32'h4000_5884
`define ADDR_IRQ_SELECT_HIGH 32'h4000_5888
`define ADDR_CONV_TRIGGER_CFG 32'h4000_588C
`define ADDR_SOFTWARE_INPUT_LOW 32'h4000_5890
`define ADDR_ELEMENT_OUTPUT_LOW 32'h4000_5898
`define ADDR_ELEMENT_OUTPUT_HIGH 32'h4000_589C
`define ADDR_CONFIG_WRITE_LOCK 32'h4000_58A0
`define ADDR_EVENT_STATUS 32'h4000_58A4
`define ADDR_EVENT_MASK 32'h4000_58A8

// field positions of the two interrupt select registers
`define SRC_LO_MSB 3
`define SRC_LO_LSB 0
`define EN_LO_BIT 4
`define SRC_HI_MSB 11
`define SRC_HI_LSB 8
`define EN_HI_BIT 12
`define IRQ_SELECT_WMASK 16'h1F1F

// conversion trigger register fields
`define CONV_SRC_MSB 4
`define CONV_SRC_LSB 0
`define CONV_EN_BIT 5
`define CONV_CFG_WMASK 16'h003F

// lock bit and offset added to upper-block source numbers
`define LOCK_BIT 0
`define HIGH_BLOCK_BASE 5'h10

// event status and mask layout
`define EVENT_BITS 5
`define EVENT_CONV_BIT 4

`define REG_RESET 16'h0000
`define EVENT_RESET 5'h00

`endif

// File: core/pla_tail_pkg.sv
package pla_tail_pkg;

  typedef struct packed {
    logic [15:0] irq_select_low_blocks;
    logic [15:0] irq_select_high_blocks;
    logic [15:0] conversion_trigger_config;
    logic [15:0] software_input_low_blocks;
    logic lock;
    logic [4:0] event_status;
    logic [4:0] event_mask;
    logic [4:0] read_snapshot;
    logic [3:0] event_req;
    logic conv_req;
    logic [31:0] prdata;
    logic pslverr;
  } regs_state_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } apb_resp_type;

endpackage

// File: core/logic_array_irq_trigger_lock_regs.sv
`timescale 1ns/1ns
`include "pla_tail_map.svh"

module logic_array_irq_trigger_lock_regs #(
  parameter int ELEMENTS = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire pla_tail_pkg::apb_req_type apb_req,
  output pla_tail_pkg::apb_resp_type apb_resp,
  input wire logic [ELEMENTS-1:0] element_out,
  input wire logic [15:0] element_input_selector,
  input wire logic [15:0] even_feedback,
  output logic [15:0] element_data_in,
  output logic [3:0] event_req,
  output logic conversion_start_req,
  output logic config_locked,
  output logic irq
);
  import pla_tail_pkg::*;

  regs_state_type state_ff;
  regs_state_type nxt_state;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic pick_element(input logic [ELEMENTS-1:0] outs,
                                        input logic [4:0] index);
    pick_element = outs[index];
  endfunction

  function automatic logic [31:0] widen(input logic [15:0] value);
    widen = {16'h0000, value};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // address decode

  logic setup_phase;
  logic access_phase;
  logic hit_irq_low;
  logic hit_irq_high;
  logic hit_conv;
  logic hit_din;
  logic hit_dout_low;
  logic hit_dout_high;
  logic hit_lock;
  logic hit_status;
  logic hit_mask;
  logic mapped;

  assign setup_phase = apb_req.psel && !apb_req.penable;
  assign access_phase = apb_req.psel && apb_req.penable;
  assign hit_irq_low = apb_req.paddr == `ADDR_IRQ_SELECT_LOW;
  assign hit_irq_high = apb_req.paddr == `ADDR_IRQ_SELECT_HIGH;
  assign hit_conv = apb_req.paddr == `ADDR_CONV_TRIGGER_CFG;
  assign hit_din = apb_req.paddr == `ADDR_SOFTWARE_INPUT_LOW;
  assign hit_dout_low = apb_req.paddr == `ADDR_ELEMENT_OUTPUT_LOW;
  assign hit_dout_high = apb_req.paddr == `ADDR_ELEMENT_OUTPUT_HIGH;
  assign hit_lock = apb_req.paddr == `ADDR_CONFIG_WRITE_LOCK;
  assign hit_status = apb_req.paddr == `ADDR_EVENT_STATUS;
  assign hit_mask = apb_req.paddr == `ADDR_EVENT_MASK;
  assign mapped = hit_irq_low || hit_irq_high || hit_conv || hit_din || hit_dout_low
                  || hit_dout_high || hit_lock || hit_status || hit_mask;

  ////////////////////////////////////////////////////////////////////////////////
  // event sources

  logic [4:0] src_a;
  logic [4:0] src_b;
  logic [4:0] src_c;
  logic [4:0] src_d;
  logic [3:0] raw_event;
  logic raw_conv;

  assign src_a = {1'b0, state_ff.irq_select_low_blocks[`SRC_LO_MSB:`SRC_LO_LSB]};
  assign src_b = {1'b0, state_ff.irq_select_low_blocks[`SRC_HI_MSB:`SRC_HI_LSB]};
  assign src_c = `HIGH_BLOCK_BASE
                 + {1'b0, state_ff.irq_select_high_blocks[`SRC_LO_MSB:`SRC_LO_LSB]};
  assign src_d = `HIGH_BLOCK_BASE
                 + {1'b0, state_ff.irq_select_high_blocks[`SRC_HI_MSB:`SRC_HI_LSB]};

  always_comb begin
    raw_event[0] = state_ff.irq_select_low_blocks[`EN_LO_BIT]
                   && pick_element(element_out, src_a);
    raw_event[1] = state_ff.irq_select_low_blocks[`EN_HI_BIT]
                   && pick_element(element_out, src_b);
    raw_event[2] = state_ff.irq_select_high_blocks[`EN_LO_BIT]
                   && pick_element(element_out, src_c);
    raw_event[3] = state_ff.irq_select_high_blocks[`EN_HI_BIT]
                   && pick_element(element_out, src_d);
    raw_conv = state_ff.conversion_trigger_config[`CONV_EN_BIT]
               && pick_element(element_out,
                  state_ff.conversion_trigger_config[`CONV_SRC_MSB:`CONV_SRC_LSB]);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic write_ok;
    logic [4:0] new_events;
    write_ok = 1'b0;
    new_events = {raw_conv, raw_event};
    nxt_state = state_ff;
    nxt_state.event_req = raw_event;
    nxt_state.conv_req = raw_conv;
    write_ok = access_phase && apb_req.pwrite && !state_ff.lock;

    // read data captured in setup so the data output comes from a flip-flop
    if (setup_phase) begin
      nxt_state.prdata = 32'h0000_0000;
      nxt_state.pslverr = !mapped;
      nxt_state.read_snapshot = `EVENT_RESET;
      if (!apb_req.pwrite) begin
        if (hit_irq_low) begin
          nxt_state.prdata = widen(state_ff.irq_select_low_blocks);
        end
        if (hit_irq_high) begin
          nxt_state.prdata = widen(state_ff.irq_select_high_blocks);
        end
        if (hit_conv) begin
          nxt_state.prdata = widen(state_ff.conversion_trigger_config);
        end
        if (hit_din) begin
          nxt_state.prdata = widen(state_ff.software_input_low_blocks);
        end
        if (hit_dout_low) begin
          nxt_state.prdata = widen(element_out[15:0]);
        end
        if (hit_dout_high) begin
          nxt_state.prdata = widen(element_out[31:16]);
        end
        if (hit_lock) begin
          nxt_state.prdata = {31'h0000_0000, state_ff.lock};
        end
        if (hit_status) begin
          nxt_state.prdata = {27'h000_0000, state_ff.event_status};
          nxt_state.read_snapshot = state_ff.event_status;
        end
        if (hit_mask) begin
          nxt_state.prdata = {27'h000_0000, state_ff.event_mask};
        end
      end
    end

    if (write_ok) begin
      if (hit_irq_low) begin
        nxt_state.irq_select_low_blocks = apb_req.pwdata[15:0] & `IRQ_SELECT_WMASK;
      end
      if (hit_irq_high) begin
        nxt_state.irq_select_high_blocks = apb_req.pwdata[15:0] & `IRQ_SELECT_WMASK;
      end
      if (hit_conv) begin
        nxt_state.conversion_trigger_config = apb_req.pwdata[15:0] & `CONV_CFG_WMASK;
      end
      if (hit_din) begin
        nxt_state.software_input_low_blocks = apb_req.pwdata[15:0];
      end
    end

    // set once, cleared only by reset
    if (access_phase && apb_req.pwrite && hit_lock && apb_req.pwdata[`LOCK_BIT]) begin
      nxt_state.lock = 1'b1;
    end

    if (access_phase && apb_req.pwrite && hit_mask) begin
      nxt_state.event_mask = apb_req.pwdata[`EVENT_BITS-1:0];
    end

    // read clears only what was seen; a new event in the same cycle wins
    if (access_phase && !apb_req.pwrite && hit_status) begin
      nxt_state.event_status = (state_ff.event_status & ~state_ff.read_snapshot)
                               | new_events;
    end else begin
      nxt_state.event_status = state_ff.event_status | new_events;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  // one driver for the whole response struct
  assign apb_resp = '{pready: 1'b1,
                      prdata: state_ff.prdata,
                      pslverr: state_ff.pslverr && access_phase};

  always_comb begin
    for (int i = 0; i < 16; i++) begin
      element_data_in[i] = element_input_selector[i] ? even_feedback[i]
                                                     : state_ff.software_input_low_blocks[i];
    end
  end

  assign event_req = state_ff.event_req;
  assign conversion_start_req = state_ff.conv_req;
  assign config_locked = state_ff.lock;
  assign irq = |(state_ff.event_status & state_ff.event_mask);

endmodule

// File: verification/pla_tail_monitor.sv
`timescale 1ns/1ns
`include "pla_tail_map.svh"
module pla_tail_monitor
  import pla_tail_pkg::*;
#(
  parameter int ELEMENTS = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire pla_tail_pkg::apb_req_type apb_req,
  input wire pla_tail_pkg::apb_resp_type apb_resp,
  input wire logic [ELEMENTS-1:0] element_out,
  input wire logic [15:0] element_input_selector,
  input wire logic [15:0] even_feedback,
  input wire logic [15:0] element_data_in,
  input wire logic [3:0] event_req,
  input wire logic conversion_start_req,
  input wire logic config_locked,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd_acc;
  logic lock_wr;
  assign rd_acc = apb_req.psel && apb_req.penable && !apb_req.pwrite;
  assign lock_wr = apb_req.psel && apb_req.penable && apb_req.pwrite
    && apb_req.paddr == `ADDR_CONFIG_WRITE_LOCK && apb_req.pwdata[0];
  sequence s_lock_wr;
    lock_wr;
  endsequence
  property p_lock_set;
    s_lock_wr |=> config_locked;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock not set");
  property p_lock_hold;
    config_locked |=> config_locked;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock cleared");
  property p_lock_src;
    !config_locked && !lock_wr |=> !config_locked;
  endproperty
  a_lock_src: assert property (p_lock_src) else $error("lock set alone");
  property p_mux;
    (element_input_selector & element_data_in) == (element_input_selector & even_feedback);
  endproperty
  a_mux: assert property (p_mux) else $error("feedback not routed");
  property p_quiet;
    element_out == '0 |=> event_req == 4'h0 && !conversion_start_req;
  endproperty
  a_quiet: assert property (p_quiet) else $error("request without source");
  property p_low_src;
    $rose(event_req[0]) |-> $past(element_out[15:0]) != 16'h0000;
  endproperty
  a_low_src: assert property (p_low_src) else $error("event a from upper");
  property p_high_src;
    $rose(event_req[2]) |-> $past(element_out[31:16]) != 16'h0000;
  endproperty
  a_high_src: assert property (p_high_src) else $error("event c from lower");
  property p_dout0;
    rd_acc && apb_req.paddr == `ADDR_ELEMENT_OUTPUT_LOW
      |-> apb_resp.prdata == {16'h0000, $past(element_out[15:0])};
  endproperty
  a_dout0: assert property (p_dout0) else $error("low outputs wrong");
  property p_dout1;
    rd_acc && apb_req.paddr == `ADDR_ELEMENT_OUTPUT_HIGH
      |-> apb_resp.prdata == {16'h0000, $past(element_out[31:16])};
  endproperty
  a_dout1: assert property (p_dout1) else $error("high outputs wrong");
endmodule

bind logic_array_irq_trigger_lock_regs pla_tail_monitor #(.ELEMENTS(ELEMENTS)) mon (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_resp(apb_resp),
  .element_out(element_out), .element_input_selector(element_input_selector),
  .even_feedback(even_feedback), .element_data_in(element_data_in),
  .event_req(event_req), .conversion_start_req(conversion_start_req),
  .config_locked(config_locked), .irq(irq));

// File: verification/tb.sv
`timescale 1ns/1ns
`include "pla_tail_map.svh"
module tb;
  import pla_tail_pkg::*;
  logic pclk = 0;
  logic presetn = 0;
  apb_req_type req = '0;
  apb_resp_type resp;
  logic [31:0] eo = '0;
  logic [31:0] r;
  logic [15:0] sel = '0;
  logic [15:0] fb = '0;
  logic [15:0] edi, din, lo, hi, cf;
  logic [3:0] ev;
  logic cs, lk, irq, e;
  int n_fail = 0;
  int n_tests = 0;
  logic [31:0] regs [9] = '{`ADDR_IRQ_SELECT_LOW, `ADDR_IRQ_SELECT_HIGH, `ADDR_CONV_TRIGGER_CFG,
    `ADDR_SOFTWARE_INPUT_LOW, `ADDR_ELEMENT_OUTPUT_LOW, `ADDR_ELEMENT_OUTPUT_HIGH,
    `ADDR_CONFIG_WRITE_LOCK, `ADDR_EVENT_STATUS, `ADDR_EVENT_MASK};
  logic_array_irq_trigger_lock_regs #(.ELEMENTS(32)) dut (.pclk(pclk), .presetn(presetn),
    .apb_req(req), .apb_resp(resp), .element_out(eo), .element_input_selector(sel),
    .even_feedback(fb), .element_data_in(edi), .event_req(ev), .conversion_start_req(cs),
    .config_locked(lk), .irq(irq));
  initial forever #25 pclk = ~pclk;
  ////////////////////////////////////////
  task conclude;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      n_fail++;
      $display("[ERR] %0t saw %h expected %h", $time, s, x);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (resp.pready !== 1'b1 && i < 16);
    if (i >= 16) begin
      n_fail++;
      conclude();
    end
    r = resp.prdata;
    e = resp.pslverr;
    req <= '0;
  endtask
  task rd(input logic [31:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  function logic [4:0] expv(input logic [15:0] l, h, c, input logic [31:0] o);
    return {c[5] & o[c[4:0]], h[12] & o[{1'b1, h[11:8]}], h[4] & o[{1'b1, h[3:0]}],
      l[12] & o[l[11:8]], l[4] & o[l[3:0]]};
  endfunction
  ////////////////////////////////////////
  initial begin
    r = $urandom(32'h170D);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    foreach (regs[k]) rd(regs[k], 32'h0);
    apb(1'b0, 32'h4000_58B0, 32'h0);
    chk(e, 1'b1);
    for (int k = 0; k < 24; k++) begin
      lo = (k == 0) ? 16'hFFFF : 16'($urandom);
      hi = (k == 0) ? 16'hFFFF : 16'($urandom);
      cf = (k == 0) ? 16'hFFFF : 16'($urandom);
      din = 16'($urandom);
      apb(1'b1, `ADDR_IRQ_SELECT_LOW, {16'h0, lo});
      apb(1'b1, `ADDR_IRQ_SELECT_HIGH, {16'h0, hi});
      apb(1'b1, `ADDR_CONV_TRIGGER_CFG, {16'h0, cf});
      apb(1'b1, `ADDR_SOFTWARE_INPUT_LOW, {16'h0, din});
      eo <= (k == 0) ? 32'hFFFF_FFFF : $urandom;
      sel <= 16'($urandom);
      fb <= 16'($urandom);
      tick(2);
      chk({cs, ev}, expv(lo, hi, cf, eo));
      chk(edi, (sel & fb) | (~sel & din));
      chk(irq, 1'b0);
      rd(`ADDR_IRQ_SELECT_LOW, {16'h0, lo & 16'h1F1F});
      rd(`ADDR_IRQ_SELECT_HIGH, {16'h0, hi & 16'h1F1F});
      rd(`ADDR_CONV_TRIGGER_CFG, {16'h0, cf & 16'h003F});
      rd(`ADDR_ELEMENT_OUTPUT_LOW, {16'h0, eo[15:0]});
      rd(`ADDR_ELEMENT_OUTPUT_HIGH, {16'h0, eo[31:16]});
    end
    ////////////////////////////////////////
    apb(1'b1, `ADDR_CONV_TRIGGER_CFG, 32'h0);
    apb(1'b1, `ADDR_IRQ_SELECT_LOW, 32'h0013);
    eo <= 32'h0;
    tick(2);
    apb(1'b0, `ADDR_EVENT_STATUS, 32'h0);
    rd(`ADDR_EVENT_STATUS, 32'h0);
    apb(1'b1, `ADDR_EVENT_MASK, 32'h1E);
    eo <= 32'h8;
    tick(2);
    chk(irq, 1'b0);
    apb(1'b1, `ADDR_EVENT_MASK, 32'h1);
    tick(1);
    chk(irq, 1'b1);
    @(posedge pclk);
    eo <= 32'h0;
    tick(2);
    rd(`ADDR_EVENT_STATUS, 32'h1);
    tick(1);
    chk(irq, 1'b0);
    apb(1'b1, `ADDR_CONFIG_WRITE_LOCK, 32'h0);
    tick(1);
    chk(lk, 1'b0);
    apb(1'b1, `ADDR_CONFIG_WRITE_LOCK, 32'h1);
    tick(1);
    chk(lk, 1'b1);
    apb(1'b1, `ADDR_IRQ_SELECT_LOW, 32'h1F1F);
    rd(`ADDR_IRQ_SELECT_LOW, 32'h0013);
    apb(1'b1, `ADDR_CONFIG_WRITE_LOCK, 32'h0);
    rd(`ADDR_CONFIG_WRITE_LOCK, 32'h1);
    conclude();
  end
endmodule
